/* File: bench/sdr_diag_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sdr_diag_top_tb_top;
  logic clk_sys, rst, fault_reset, quick_stop_done, wr_en, rd_en, rd_valid_q;
  logic quick_stop_q, fault_state_q, error_out_q;
  logic [16:0] err_act;
  logic [6:0] warn_act;
  logic [1:0] rd_sel, stat_err_class_q;
  logic [15:0] wr_data, class_one_diagnostic_q, class_two_diagnostic_q;
  logic [31:0] rd_data_q, diag_number_q, d;
  int miscompares = 0, compares = 0;
  logic [15:0] ec [17] = '{16'h5603, 16'h5600, 16'h3201, 16'h8000, 16'h5600, 16'h3201,
    16'h3200, 16'h2300, 16'h8000, 16'h8000, 16'h8000, 16'h4300, 16'h4100, 16'h4100,
    16'h4100, 16'h3300, 16'h3300};
  logic [15:0] wc [7] = '{16'hb124, 16'h3201, 16'h8000, 16'h4301, 16'h4101, 16'h8000, 16'h8000};
  sdr_diag_top sdr_diag_top_inst (.clk_sys, .rst, .err_act, .warn_act, .fault_reset,
    .quick_stop_done, .rd_en, .rd_sel, .wr_data, .wr_en, .rd_data_q, .rd_valid_q,
    .stat_err_class_q, .quick_stop_q, .fault_state_q, .error_out_q, .diag_number_q,
    .class_one_diagnostic_q, .class_two_diagnostic_q);
  sdr_master sdr_master_inst (.clk_sys, .rd_en, .rd_sel, .rd_valid_q, .rd_data_q);
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task t_idle;
    chk(diag_number_q, 32'h0);
    chk(stat_err_class_q, 2'h0);
    sdr_master_inst.rd(2'h0, d);
    chk(d, 32'h0);
    sdr_master_inst.rd(2'h2, d);
    chk(d, 32'h0);
  endtask
  task t_warn;
    warn_act = 7'h01;
    wr_en = 1'b1;
    wr_data = 16'hffff;
    step(2);
    wr_en = 1'b0;
    chk(stat_err_class_q, 2'h2);
    chk(fault_state_q, 1'b0);
    chk(quick_stop_q, 1'b0);
    sdr_master_inst.rd(2'h0, d);
    chk(d, 32'h410eb124);
    for (int i = 0; i < 7; i++)
    begin
      warn_act = 7'h01 << i;
      step(2);
      chk(diag_number_q, {16'h410e, wc[i]});
    end
    warn_act = 7'h0;
  endtask
  task t_errs;
    for (int i = 0; i < 17; i++)
    begin
      err_act = 17'h1 << i;
      step(2);
      chk(diag_number_q, {16'h410f, ec[i]});
      chk(quick_stop_q, 1'b1);
      err_act = 17'h0;
      step(2);
      chk(diag_number_q, 32'h0);
    end
    err_act = 17'h1fffe;
    warn_act = 7'h7f;
    step(2);
    chk(diag_number_q, 32'h410f5600);
    chk(stat_err_class_q, 2'h1);
    sdr_master_inst.rd(2'h1, d);
    chk(d, 32'h0000fffe);
    sdr_master_inst.rd(2'h2, d);
    chk(d, 32'h0000007f);
  endtask
  task t_reset;
    err_act = 17'h1;
    warn_act = 7'h1;
    step(2);
    chk(quick_stop_q, 1'b1);
    rst = 1'b1;
    step(1);
    chk(diag_number_q, 32'h0);
    chk(class_two_diagnostic_q, 16'h0);
    chk(quick_stop_q, 1'b0);
    {err_act, warn_act} = '0;
    rst = 1'b0;
    step(2);
    chk(diag_number_q, 32'h0);
  endtask
  task t_fault;
    quick_stop_done = 1'b1;
    step(3);
    chk(fault_state_q, 1'b1);
    chk(error_out_q, 1'b1);
    err_act = 17'h0;
    warn_act = 7'h0;
    quick_stop_done = 1'b0;
    fault_reset = 1'b1;
    step(2);
    fault_reset = 1'b0;
    chk(fault_state_q, 1'b0);
  endtask
  initial
  begin
    {rst, fault_reset, quick_stop_done, wr_en, err_act, warn_act, wr_data} = '0;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    t_idle;
    t_warn;
    t_errs;
    t_fault;
    t_reset;
    close_out;
  end
  initial
  begin
    #1000000;
    miscompares++;
    close_out;
  end
endmodule
bind sdr_diag_top sdr_sva sdr_sva_inst (.clk_sys, .rst, .err_act, .warn_act, .quick_stop_done,
  .rd_en, .rd_valid_q, .stat_err_class_q, .quick_stop_q, .fault_state_q, .error_out_q,
  .diag_number_q, .class_one_diagnostic_q, .class_two_diagnostic_q);
`default_nettype wire

/* File: bench/sdr_master.sv */
`timescale 1ns/100ps
`default_nettype none
module sdr_master (
  input wire logic clk_sys,
  output logic rd_en,
  output logic [1:0] rd_sel,
  input wire logic rd_valid_q,
  input wire logic [31:0] rd_data_q
);
  initial rd_en = 1'b0;
  initial rd_sel = 2'h0;
  // a missing answer is corrupted, never trusted
  task automatic rd(input logic [1:0] s, output logic [31:0] d);
    @(negedge clk_sys);
    rd_en = 1'b1;
    rd_sel = s;
    @(negedge clk_sys);
    rd_en = 1'b0;
    d = rd_valid_q ? rd_data_q : ~rd_data_q;
  endtask
endmodule
`default_nettype wire

/* File: bench/sdr_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sdr_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [16:0] err_act,
  input wire logic [6:0] warn_act,
  input wire logic quick_stop_done,
  input wire logic rd_en,
  input wire logic rd_valid_q,
  input wire logic [1:0] stat_err_class_q,
  input wire logic quick_stop_q,
  input wire logic fault_state_q,
  input wire logic error_out_q,
  input wire logic [31:0] diag_number_q,
  input wire logic [15:0] class_one_diagnostic_q,
  input wire logic [15:0] class_two_diagnostic_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_stop;
    quick_stop_q ##0 quick_stop_done;
  endsequence
  a_read_answer: assert property (rd_en |=> rd_valid_q)
    else $error("read not answered");
  a_profile_bits: assert property (|diag_number_q |-> diag_number_q[31:24] == 8'h41)
    else $error("profile bits wrong");
  a_rsvd_zero: assert property (diag_number_q[23:20] == 4'h0)
    else $error("reserved bits set");
  a_level_err: assert property (|err_act |=> diag_number_q[19:16] == 4'hf && stat_err_class_q == 2'h1)
    else $error("error level wrong");
  a_level_warn: assert property (!(|err_act) && |warn_act |=> diag_number_q[19:16] == 4'he)
    else $error("warning level wrong");
  a_code_zero: assert property (!(|err_act) && !(|warn_act) |=> diag_number_q == 32'h0)
    else $error("idle code not zero");
  a_first_err: assert property (err_act[0] |=> diag_number_q[15:0] == 16'h5603)
    else $error("top error code wrong");
  a_err_out: assert property (error_out_q == fault_state_q)
    else $error("error output mismatch");
  a_fault_entry: assert property (s_stop |=> fault_state_q)
    else $error("no fault after stop");
  a_warn_word: assert property (1'b1 |=> class_two_diagnostic_q == {9'h0, $past(warn_act)})
    else $error("warning word wrong");
  sequence s_run_idle;
    !quick_stop_q && !fault_state_q;
  endsequence
  a_err_stop: assert property (s_run_idle ##0 (|err_act) |=> quick_stop_q)
    else $error("error did not stop");
  a_warn_no_move: assert property (s_run_idle ##0 !(|err_act) |=> s_run_idle)
    else $error("state moved without error");
  a_err_word: assert property (1'b1 |=> class_one_diagnostic_q == $past(err_act[15:0]))
    else $error("error word wrong");
endmodule
`default_nettype wire

/* File: hw/sdr_code_map.v */
`timescale 1ns/100ps
`default_nettype none
`include "sdr_regs.vh"
// priority encoder: lowest index wins; errors before warnings
module sdr_code_map (
  input wire [`SDR_NUM_ERR-1:0] err_act,
  input wire [`SDR_NUM_WARN-1:0] warn_act,
  output reg [15:0] code,
  output reg is_err,
  output reg any
);
  integer i;
  reg [15:0] etab [0:`SDR_NUM_ERR-1];
  reg [15:0] wtab [0:`SDR_NUM_WARN-1];
  always @*
  begin
    etab[0] = `SDR_EN_5603;
    etab[1] = `SDR_EN_5600;
    etab[2] = `SDR_EN_3201;
    etab[3] = `SDR_EN_8000;
    etab[4] = `SDR_EN_5600;
    etab[5] = `SDR_EN_3201;
    etab[6] = `SDR_EN_3200;
    etab[7] = `SDR_EN_2300;
    etab[8] = `SDR_EN_8000;
    etab[9] = `SDR_EN_8000;
    etab[10] = `SDR_EN_8000;
    etab[11] = `SDR_EN_4300;
    etab[12] = `SDR_EN_4100;
    etab[13] = `SDR_EN_4100;
    etab[14] = `SDR_EN_4100;
    etab[15] = `SDR_EN_3300;
    etab[16] = `SDR_EN_3300;
    wtab[0] = `SDR_EN_B124;
    wtab[1] = `SDR_EN_3201;
    wtab[2] = `SDR_EN_8000;
    wtab[3] = `SDR_EN_4301;
    wtab[4] = `SDR_EN_4101;
    wtab[5] = `SDR_EN_8000;
    wtab[6] = `SDR_EN_8000;
    code = 16'h0000;
    is_err = 1'b0;
    any = 1'b0;
    // scan backwards so the lowest index is the last assignment
    for (i = `SDR_NUM_WARN - 1; i >= 0; i = i - 1)
      if (warn_act[i])
      begin
        code = wtab[i];
        any = 1'b1;
      end
    for (i = `SDR_NUM_ERR - 1; i >= 0; i = i - 1)
      if (err_act[i])
      begin
        code = etab[i];
        is_err = 1'b1;
        any = 1'b1;
      end
  end
endmodule
`default_nettype wire

/* File: hw/sdr_diag_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "sdr_regs.vh"
module sdr_diag_top (
  input wire clk_sys,
  input wire rst,
  input wire [`SDR_NUM_ERR-1:0] err_act,
  input wire [`SDR_NUM_WARN-1:0] warn_act,
  input wire fault_reset,
  input wire quick_stop_done,
  input wire rd_en,
  input wire [1:0] rd_sel,
  input wire [15:0] wr_data,
  input wire wr_en,
  output reg [31:0] rd_data_q,
  output reg rd_valid_q,
  output reg [1:0] stat_err_class_q,
  output reg quick_stop_q,
  output reg fault_state_q,
  output reg error_out_q,
  output reg [31:0] diag_number_q,
  output reg [15:0] class_one_diagnostic_q,
  output reg [15:0] class_two_diagnostic_q
);
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_QSTOP = 3'b010;
  localparam [2:0] ST_FAULT = 3'b100;

  wire [15:0] map_code;
  wire map_err;
  wire map_any;
  wire [15:0] c1_d;
  wire [15:0] c2_d;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] diag_d;
  reg [3:0] level_d;
  reg [1:0] class_d;
  reg [31:0] rd_d;
  reg quick_stop_d;
  reg fault_d;
  genvar g;

  sdr_code_map u_map (
    .err_act(err_act),
    .warn_act(warn_act),
    .code(map_code),
    .is_err(map_err),
    .any(map_any)
  );

  // errors outrank warnings, so the level follows the winner
  always @*
  begin
    if (map_err)
      level_d = `SDR_LEVEL_ALARM;
    else
      level_d = `SDR_LEVEL_ALERT;
  end

  // an idle drive reads all zero, profile bits included
  always @*
  begin
    diag_d = `SDR_DIAG_RESET;
    if (map_any)
    begin
      diag_d[`SDR_CODE_MSB:`SDR_CODE_LSB] = map_code;
      diag_d[`SDR_LEVEL_MSB:`SDR_LEVEL_LSB] = level_d;
      diag_d[`SDR_RSVD_MSB:`SDR_RSVD_LSB] = `SDR_RSVD_VAL;
      diag_d[`SDR_PROFILE_MSB:`SDR_PROFILE_LSB] = `SDR_PROFILE_VAL;
      diag_d[`SDR_SPEC_MSB:`SDR_SPEC_LSB] = `SDR_SPEC_VAL;
    end
  end

  // status field: any error hides the warnings
  always @*
  begin
    case ({map_err, map_any})
      2'b11: class_d = `SDR_CLASS_ONE;
      2'b01: class_d = `SDR_CLASS_TWO;
      default: class_d = `SDR_CLASS_NONE;
    endcase
  end

  // one flag bit per event source; error source 16 has no room in the word
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_bits
      if (g < `SDR_NUM_ERR)
      begin : g_err
        assign c1_d[g] = err_act[g];
      end
      else
      begin : g_err_pad
        assign c1_d[g] = 1'b0;
      end
      if (g < `SDR_NUM_WARN)
      begin : g_warn
        assign c2_d[g] = warn_act[g];
      end
      else
      begin : g_warn_pad
        assign c2_d[g] = 1'b0;
      end
    end
  endgenerate

  // warnings never enter this machine
  always @*
  begin
    case (state_q)
      ST_RUN:
      begin
        if (map_err)
          state_d = ST_QSTOP;
        else
          state_d = ST_RUN;
      end
      ST_QSTOP:
      begin
        if (quick_stop_done)
          state_d = ST_FAULT;
        else
          state_d = ST_QSTOP;
      end
      ST_FAULT:
      begin
        // stay put while any error is still pending
        if (fault_reset && !map_err)
          state_d = ST_RUN;
        else
          state_d = ST_FAULT;
      end
      default:
        state_d = ST_FAULT;
    endcase
  end

  // outputs follow the next state so they line up with state_q
  always @*
  begin
    quick_stop_d = (state_d == ST_QSTOP);
    fault_d = (state_d == ST_FAULT);
  end

  // a read returns the value registered before the strobe edge
  always @*
  begin
    case (rd_sel)
      `SDR_SEL_DIAG: rd_d = diag_number_q;
      `SDR_SEL_C1: rd_d = {16'h0000, class_one_diagnostic_q};
      `SDR_SEL_C2: rd_d = {16'h0000, class_two_diagnostic_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      diag_number_q <= `SDR_DIAG_RESET;
      class_one_diagnostic_q <= `SDR_WORD_RESET;
      class_two_diagnostic_q <= `SDR_WORD_RESET;
      stat_err_class_q <= `SDR_CLASS_NONE;
    end
    else
    begin
      diag_number_q <= diag_d;
      class_one_diagnostic_q <= c1_d;
      class_two_diagnostic_q <= c2_d;
      stat_err_class_q <= class_d;
    end
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      quick_stop_q <= 1'b0;
      fault_state_q <= 1'b0;
      error_out_q <= 1'b0;
    end
    else
    begin
      quick_stop_q <= quick_stop_d;
      fault_state_q <= fault_d;
      error_out_q <= fault_d;
    end
  end

  // wr_data/wr_en accepted but ignored: all registers read-only
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_en;
      // data holds between reads so a slow master can still pick it up
      if (rd_en)
        rd_data_q <= rd_d;
    end
  end
endmodule
`default_nettype wire

/* File: hw/sdr_regs.vh */
`ifndef SDR_REGS_VH
`define SDR_REGS_VH
// diagnostic number layout
`define SDR_CODE_LSB 0
`define SDR_CODE_MSB 15
`define SDR_LEVEL_LSB 16
`define SDR_LEVEL_MSB 19
`define SDR_PROFILE_LSB 24
`define SDR_PROFILE_MSB 29
`define SDR_SPEC_LSB 30
`define SDR_SPEC_MSB 31
`define SDR_RSVD_LSB 20
`define SDR_RSVD_MSB 23
`define SDR_LEVEL_ALERT 4'he
`define SDR_LEVEL_ALARM 4'hf
`define SDR_PROFILE_VAL 6'h01
`define SDR_SPEC_VAL 2'h1
`define SDR_RSVD_VAL 4'h0
`define SDR_DIAG_RESET 32'h0000_0000
`define SDR_WORD_RESET 16'h0000
// drive status word error class field
`define SDR_STAT_CLASS_LSB 12
`define SDR_STAT_CLASS_MSB 13
`define SDR_CLASS_NONE 2'h0
`define SDR_CLASS_ONE 2'h1
`define SDR_CLASS_TWO 2'h2
// event counts and register selects
`define SDR_NUM_ERR 17
`define SDR_NUM_WARN 7
`define SDR_SEL_DIAG 2'h0
`define SDR_SEL_C1 2'h1
`define SDR_SEL_C2 2'h2
// error numbers
`define SDR_EN_5603 16'h5603
`define SDR_EN_5600 16'h5600
`define SDR_EN_3201 16'h3201
`define SDR_EN_8000 16'h8000
`define SDR_EN_3200 16'h3200
`define SDR_EN_2300 16'h2300
`define SDR_EN_4300 16'h4300
`define SDR_EN_4100 16'h4100
`define SDR_EN_3300 16'h3300
`define SDR_EN_B124 16'hb124
`define SDR_EN_4301 16'h4301
`define SDR_EN_4101 16'h4101
`endif
